// ===== static_mem_cs_timing_config.sv
`timescale 1ns/1ps
module static_mem_cs_timing_config
   import static_mem_cfg_pkg::*;
(
   input wire logic pclk, // apb clock
   input wire logic presetn, // async reset
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic req_valid, // access request
   input wire mem_req_t req, // access fields
   output logic req_ready, // access taken
   output logic [15:0] rd_data, // read data
   output logic rd_valid, // read data pulse
   output logic [23:0] ext_addr, // memory address
   output logic [15:0] ext_data_out, // data to pins
   output logic ext_data_oe, // data drive enable
   input wire logic [15:0] ext_data_in, // data from pins
   output logic [NUM_CS-1:0] ext_chip_select_n, // chip selects
   output logic read_strobe_n, // read strobe
   output logic write_strobe_n, // write strobe
   output logic byte_select_lo_n, // low byte select
   output logic byte_select_hi_n, // high byte select
   output logic byte_write_strobe_lo_n, // low byte write
   output logic byte_write_strobe_hi_n, // high byte write
   input wire logic ext_wait_n // wait pin
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ACC = 3'b010,
      ST_DONE = 3'b100
   } state_t;

   timing_t stage_r [NUM_CS];
   timing_t act_r [NUM_CS];
   logic [31:0] mode_r [NUM_CS];
   logic [31:0] prdata_r, prdata_nxt;
   logic err, wr_en;
   logic [1:0] sel_cs;
   logic [3:0] ofs;

   assign sel_cs = paddr[5:4];
   assign ofs = paddr[3:0];
   assign err = (paddr[11:6] != CS_SEL_HI) || (paddr[1:0] != 2'h0);
   assign wr_en = psel && penable && pwrite && !err;
   assign pready = 1'b1;
   assign pslverr = psel && penable && err;
   assign prdata = prdata_r;

   // per chip select register group at 0x10 stride
   for (genvar i = 0; i < NUM_CS; i++) begin : g_cs
      timing_t st_nxt, ac_nxt;
      logic [31:0] md_nxt;
      logic hit;
      assign hit = wr_en && (sel_cs == 2'(i)); // R01
      always_comb begin
         st_nxt = stage_r[i];
         ac_nxt = act_r[i];
         md_nxt = mode_r[i];
         if (hit && ofs == OFS_SETUP) begin
            st_nxt.setup = pwdata & MSK_SETUP;
         end else if (hit && ofs == OFS_PULSE) begin
            st_nxt.pulse = pwdata & MSK_PULSE;
         end else if (hit && ofs == OFS_CYCLE) begin
            st_nxt.cycle = pwdata & MSK_CYCLE;
         end else if (hit && ofs == OFS_MODE) begin
            md_nxt = pwdata & MSK_MODE;
            ac_nxt = stage_r[i]; // R22
         end
      end
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            stage_r[i] <= '{RST_SETUP, RST_PULSE, RST_CYCLE};
            act_r[i] <= '{RST_SETUP, RST_PULSE, RST_CYCLE};
            mode_r[i] <= RST_MODE;
         end else begin
            stage_r[i] <= st_nxt;
            act_r[i] <= ac_nxt;
            mode_r[i] <= md_nxt;
         end
      end
   end

   always_comb begin
      prdata_nxt = prdata_r;
      if (psel && !penable) begin
         if (err) begin
            prdata_nxt = 32'h00000000;
         end else if (ofs == OFS_SETUP) begin
            prdata_nxt = stage_r[sel_cs].setup;
         end else if (ofs == OFS_PULSE) begin
            prdata_nxt = stage_r[sel_cs].pulse;
         end else if (ofs == OFS_CYCLE) begin
            prdata_nxt = stage_r[sel_cs].cycle;
         end else begin
            prdata_nxt = mode_r[sel_cs];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
      end else begin
         prdata_r <= prdata_nxt;
      end
   end

   // pin synchronisers
   logic wait_m_r, wait_s_r;
   logic [15:0] din_m_r, din_s_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_m_r <= 1'b1;
         wait_s_r <= 1'b1;
         din_m_r <= 16'h0000;
         din_s_r <= 16'h0000;
      end else begin
         wait_m_r <= ext_wait_n;
         wait_s_r <= wait_m_r;
         din_m_r <= ext_data_in;
         din_s_r <= din_m_r;
      end
   end

   // access engine
   state_t state_r, state_nxt;
   mem_req_t cur_r, cur_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic [4:0] float_r, float_nxt;
   logic hit_r, hit_nxt, page_v_r, page_v_nxt;
   logic [1:0] page_cs_r, page_cs_nxt;
   logic [23:0] page_a_r, page_a_nxt;
   logic [15:0] rd_data_r, rd_data_nxt;
   logic rd_valid_r, rd_valid_nxt;
   logic [NUM_CS-1:0] cs_n_r, cs_n_nxt;
   logic rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt;
   logic bs_lo_r, bs_lo_nxt, bs_hi_r, bs_hi_nxt;
   logic bw_lo_r, bw_lo_nxt, bw_hi_r, bw_hi_nxt;
   logic oe_r, oe_nxt;
   logic [31:0] m;
   timing_t t;
   logic [CW-1:0] cs_su, cs_pl, st_su, st_pl, cyc, pl_pg, ct_su, ct_pl;
   logic page_acc, ctrl_st, in_cs, in_st, ct_pulse, ct_last;
   logic wait_act, hold, last, start_ok, hit_now, acc, bus16, bat1;
   logic [1:0] wmode;
   logic [23:0] pmask;

   assign m = mode_r[cur_r.cs];
   assign t = act_r[cur_r.cs];
   assign acc = (state_r == ST_ACC);
   assign page_acc = !cur_r.write && m[M_PAGE_EN]; // R10
   assign pl_pg = hit_r ? pulse_len(t.pulse[F_ST_RD+:7]) : pulse_len(t.pulse[F_CS_RD+:7]); // R06

   always_comb begin
      if (cur_r.write) begin
         cs_su = setup_len(t.setup[F_CS_WR+:6]); // R03
         st_su = setup_len(t.setup[F_ST_WR+:6]);
         cs_pl = pulse_len(t.pulse[F_CS_WR+:7]); // R04
         st_pl = pulse_len(t.pulse[F_ST_WR+:7]);
         cyc = cycle_len(t.cycle[F_CYC_WR+:9]); // R07
      end else if (page_acc) begin
         cs_su = '0;
         st_su = '0;
         cs_pl = pl_pg;
         st_pl = pl_pg;
         cyc = pl_pg;
      end else begin
         cs_su = setup_len(t.setup[F_CS_RD+:6]);
         st_su = setup_len(t.setup[F_ST_RD+:6]);
         cs_pl = pulse_len(t.pulse[F_CS_RD+:7]);
         st_pl = pulse_len(t.pulse[F_ST_RD+:7]);
         cyc = cycle_len(t.cycle[F_CYC_RD+:9]);
      end
   end

   assign ctrl_st = cur_r.write ? m[M_WR_CTRL] : m[M_RD_CTRL]; // R20 R21
   assign ct_su = ctrl_st ? st_su : cs_su;
   assign ct_pl = ctrl_st ? st_pl : cs_pl;
   assign in_cs = (cnt_r >= cs_su) && (cnt_r < cs_su + cs_pl);
   assign in_st = (cnt_r >= st_su) && (cnt_r < st_su + st_pl);
   assign ct_pulse = (cnt_r >= ct_su) && (cnt_r < ct_su + ct_pl);
   assign ct_last = ct_pulse && (cnt_r + 11'h001 == ct_su + ct_pl);
   assign wmode = page_acc ? WAIT_OFF : m[M_WAIT+:2]; // R17
   assign wait_act = !wait_s_r;
   assign bus16 = (m[M_DBW+:2] == DBW_16); // R13
   assign bat1 = bus16 && m[M_BAT]; // R14

   always_comb begin
      hold = 1'b0;
      if (wmode == WAIT_FROZEN && ct_pulse && wait_act) begin
         hold = 1'b1; // R15 R18
      end else if (wmode == WAIT_READY && ct_last && wait_act) begin
         hold = 1'b1; // R19
      end else if (m[M_FLOAT_OPT] && cnt_r == ct_su && float_r != 5'h00) begin
         hold = 1'b1; // R11
      end
   end

   assign last = (cnt_r + 11'h001 >= cyc) && !hold; // R08

   assign pmask = ~((PAGE_BASE << mode_r[req.cs][M_PS+:2]) - 24'h000001); // R09
   assign hit_now = page_v_r && (page_cs_r == req.cs) && ((req.addr & pmask) == (page_a_r & pmask));
   assign start_ok = (float_r == 5'h00) || mode_r[req.cs][M_FLOAT_OPT]; // R12
   assign req_ready = (state_r == ST_IDLE) && start_ok;

   always_comb begin
      state_nxt = state_r;
      cur_nxt = cur_r;
      cnt_nxt = cnt_r;
      float_nxt = (float_r != 5'h00) ? float_r - 5'h01 : float_r;
      hit_nxt = hit_r;
      page_v_nxt = page_v_r;
      page_cs_nxt = page_cs_r;
      page_a_nxt = page_a_r;
      rd_data_nxt = rd_data_r;
      rd_valid_nxt = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (req_valid && start_ok) begin
               cur_nxt = req;
               cnt_nxt = '0;
               hit_nxt = hit_now && !req.write && mode_r[req.cs][M_PAGE_EN];
               state_nxt = ST_ACC;
            end
         end
         ST_ACC: begin
            if (!cur_r.write && ct_last && !hold) begin
               rd_data_nxt = din_s_r;
            end
            if (last) begin
               state_nxt = ST_DONE;
               rd_valid_nxt = !cur_r.write;
               page_v_nxt = page_acc;
               page_cs_nxt = cur_r.cs;
               page_a_nxt = cur_r.addr;
               if (!cur_r.write) begin
                  float_nxt = {1'b0, m[M_FLOAT+:4]} + 5'h01; // R12
               end
            end else if (!hold) begin
               cnt_nxt = cnt_r + 11'h001;
            end
         end
         ST_DONE: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      for (int i = 0; i < NUM_CS; i++) begin
         cs_n_nxt[i] = !(acc && in_cs && cur_r.cs == 2'(i));
      end
      rd_n_nxt = !(acc && !cur_r.write && in_st);
      wr_n_nxt = !(acc && cur_r.write && in_st && !bat1); // R14
      bw_lo_nxt = !(acc && cur_r.write && in_st && bat1 && cur_r.be[0]);
      bw_hi_nxt = !(acc && cur_r.write && in_st && bat1 && cur_r.be[1]);
      bs_lo_nxt = !(acc && bus16 && !bat1 && cur_r.be[0]);
      bs_hi_nxt = !(acc && bus16 && !bat1 && cur_r.be[1]);
      oe_nxt = acc && cur_r.write;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         cur_r <= '0;
         cnt_r <= '0;
         float_r <= 5'h00;
         hit_r <= 1'b0;
         page_v_r <= 1'b0;
         page_cs_r <= 2'h0;
         page_a_r <= 24'h000000;
         rd_data_r <= 16'h0000;
         rd_valid_r <= 1'b0;
         cs_n_r <= '1;
         rd_n_r <= 1'b1;
         wr_n_r <= 1'b1;
         bw_lo_r <= 1'b1;
         bw_hi_r <= 1'b1;
         bs_lo_r <= 1'b1;
         bs_hi_r <= 1'b1;
         oe_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cur_r <= cur_nxt;
         cnt_r <= cnt_nxt;
         float_r <= float_nxt;
         hit_r <= hit_nxt;
         page_v_r <= page_v_nxt;
         page_cs_r <= page_cs_nxt;
         page_a_r <= page_a_nxt;
         rd_data_r <= rd_data_nxt;
         rd_valid_r <= rd_valid_nxt;
         cs_n_r <= cs_n_nxt;
         rd_n_r <= rd_n_nxt;
         wr_n_r <= wr_n_nxt;
         bw_lo_r <= bw_lo_nxt;
         bw_hi_r <= bw_hi_nxt;
         bs_lo_r <= bs_lo_nxt;
         bs_hi_r <= bs_hi_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign rd_data = rd_data_r;
   assign rd_valid = rd_valid_r;
   assign ext_addr = cur_r.addr;
   assign ext_data_out = cur_r.wdata;
   assign ext_data_oe = oe_r;
   assign ext_chip_select_n = cs_n_r;
   assign read_strobe_n = rd_n_r;
   assign write_strobe_n = wr_n_r;
   assign byte_select_lo_n = bs_lo_r;
   assign byte_select_hi_n = bs_hi_r;
   assign byte_write_strobe_lo_n = bw_lo_r;
   assign byte_write_strobe_hi_n = bw_hi_r;

   a_commit_apply: assert property (@(posedge pclk) disable iff (!presetn) // R22
      (wr_en && sel_cs == 2'h0 && ofs == OFS_MODE) |=> act_r[0] == $past(stage_r[0]))
      else $error("mode write did not apply staged timing");
   a_stage_hold: assert property (@(posedge pclk) disable iff (!presetn) // R22
      !(wr_en && sel_cs == 2'h0 && ofs == OFS_MODE) |=> $stable(act_r[0]))
      else $error("active timing changed without mode write");
   a_setup_idle: assert property (@(posedge pclk) disable iff (!presetn) // R03
      (acc && cnt_r < cs_su && cnt_r < st_su) |=> (&cs_n_r) && rd_n_r && wr_n_r)
      else $error("strobe active during setup");
   a_pulse_low: assert property (@(posedge pclk) disable iff (!presetn) // R04
      (acc && in_cs) |=> !cs_n_r[$past(cur_r.cs)])
      else $error("chip select high in pulse");
   a_cycle_end: assert property (@(posedge pclk) disable iff (!presetn) // R07
      (acc && last) |=> state_r == ST_DONE ##1 state_r == ST_IDLE)
      else $error("cycle did not end at length");
   a_float_bar: assert property (@(posedge pclk) disable iff (!presetn) // R12
      (float_r != 5'h00 && !mode_r[req.cs][M_FLOAT_OPT]) |-> !req_ready)
      else $error("access started during float");
   a_wait_off: assert property (@(posedge pclk) disable iff (!presetn) // R17
      (acc && wmode == WAIT_OFF && !last && cnt_r != ct_su) |=> cnt_r == $past(cnt_r) + 11'h001)
      else $error("counter stalled with wait disabled");
   a_frozen_stop: assert property (@(posedge pclk) disable iff (!presetn) // R18
      (acc && wmode == WAIT_FROZEN && ct_pulse && wait_act) |=> $stable(cnt_r) && state_r == ST_ACC)
      else $error("frozen wait did not halt");
   a_ready_ext: assert property (@(posedge pclk) disable iff (!presetn) // R19
      (acc && wmode == WAIT_READY && ct_last && wait_act) |=> $stable(cnt_r) && !rd_valid_r)
      else $error("ready wait did not extend");
   a_byte_write: assert property (@(posedge pclk) disable iff (!presetn) // R14
      (!byte_write_strobe_lo_n || !byte_write_strobe_hi_n) |-> write_strobe_n && byte_select_lo_n)
      else $error("byte write type mixed signals");
endmodule

// ===== static_mem_cfg_pkg.sv
// Function
// R01 - four registers per chip select, 0x10 stride
// R02 - software ends reconfiguration with mode write
// R03 - setup length is 128*top bit plus low five
// R04 - pulse length is 256*top bit plus low six
// R05 - software never programs zero pulse length
// R06 - page reads: first uses cs pulse, rest strobe
// R07 - cycle length is 256*bits 8:7 plus 6:0
// R08 - hold fills cycle after setup and pulse
// R09 - page size code selects 4 to 32 bytes
// R10 - page mode bit selects page or standard reads
// R11 - float optimization overlaps next setup
// R12 - float count plus turnaround bars the bus
// R13 - bus width 8 or 16 bits, bat only at 16
// R14 - byte access type picks byte selects or strobes
// R15 - wait sampled only in controlling pulse phase
// R16 - software programs hold when wait is enabled
// R17 - wait mode 0 ignores the wait input
// R18 - frozen wait mode halts and resumes the cycle
// R19 - ready wait mode extends until wait high
// R20 - write mode bit picks strobe or chip select
// R21 - read mode bit picks strobe or chip select
// R22 - new timings apply only after mode write
package static_mem_cfg_pkg;
   localparam int NUM_CS = 4;
   localparam int CW = 11;
   localparam logic [5:0] CS_SEL_HI = 6'h00;
   localparam logic [3:0] OFS_SETUP = 4'h0;
   localparam logic [3:0] OFS_PULSE = 4'h4;
   localparam logic [3:0] OFS_CYCLE = 4'h8;
   localparam logic [3:0] OFS_MODE = 4'hc;
   localparam logic [31:0] RST_SETUP = 32'h01010101;
   localparam logic [31:0] RST_PULSE = 32'h01010101;
   localparam logic [31:0] RST_CYCLE = 32'h00030003;
   localparam logic [31:0] RST_MODE = 32'h10002103;
   localparam logic [31:0] MSK_SETUP = 32'h3f3f3f3f;
   localparam logic [31:0] MSK_PULSE = 32'h7f7f7f7f;
   localparam logic [31:0] MSK_CYCLE = 32'h01ff01ff;
   localparam logic [31:0] MSK_MODE = 32'h311f3133;
   localparam int F_CS_RD = 24;
   localparam int F_ST_RD = 16;
   localparam int F_CS_WR = 8;
   localparam int F_ST_WR = 0;
   localparam int F_CYC_RD = 16;
   localparam int F_CYC_WR = 0;
   localparam int M_RD_CTRL = 0;
   localparam int M_WR_CTRL = 1;
   localparam int M_WAIT = 4;
   localparam int M_BAT = 8;
   localparam int M_DBW = 12;
   localparam int M_FLOAT = 16;
   localparam int M_FLOAT_OPT = 20;
   localparam int M_PAGE_EN = 24;
   localparam int M_PS = 28;
   localparam logic [1:0] WAIT_OFF = 2'h0;
   localparam logic [1:0] WAIT_FROZEN = 2'h2;
   localparam logic [1:0] WAIT_READY = 2'h3;
   localparam logic [1:0] DBW_16 = 2'h1;
   localparam logic [23:0] PAGE_BASE = 24'h000004;
   typedef struct packed {
      logic write;
      logic [1:0] cs;
      logic [23:0] addr;
      logic [1:0] be;
      logic [15:0] wdata;
   } mem_req_t;
   typedef struct packed {
      logic [31:0] setup;
      logic [31:0] pulse;
      logic [31:0] cycle;
   } timing_t;
   function automatic logic [CW-1:0] setup_len(input logic [5:0] f);
      setup_len = {3'h0, f[5], 2'h0, f[4:0]};
   endfunction
   function automatic logic [CW-1:0] pulse_len(input logic [6:0] f);
      pulse_len = {2'h0, f[6], 2'h0, f[5:0]};
   endfunction
   function automatic logic [CW-1:0] cycle_len(input logic [8:0] f);
      cycle_len = {1'b0, f[8:7], 1'b0, f[6:0]};
   endfunction
endpackage

// ===== static_mem_partner.sv
`timescale 1ns/1ps
module static_mem_partner
   import static_mem_cfg_pkg::*;
(
   input wire logic pclk, // clock
   input wire logic presetn, // reset
   input wire logic [NUM_CS-1:0] ext_chip_select_n, // selects
   input wire logic read_strobe_n, // read strobe
   input wire logic write_strobe_n, // write strobe
   input wire logic [23:0] ext_addr, // address
   input wire logic [15:0] ext_data_out, // write data
   input wire logic ext_data_oe, // data drive
   input wire logic [31:0] stall, // wait length
   output logic [15:0] ext_data_in, // read data
   output logic ext_wait_n, // wait pin
   output logic [15:0] wr_seen // last write data
);
   logic act_d;
   logic [15:0] last;
   int cnt;
   wire act = !read_strobe_n || !write_strobe_n;
   wire rd_on = !read_strobe_n && !(&ext_chip_select_n);
   // released once the stall has run out
   assign ext_wait_n = (cnt == 0);
   // released bus toggles so stale data never matches
   assign ext_data_in = rd_on ? (ext_addr[15:0] ^ 16'h5a5a) : ~last;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_d <= 1'b0;
         cnt <= 0;
         last <= 16'h0000;
         wr_seen <= 16'h0000;
      end else begin
         act_d <= act;
         last <= ext_data_in;
         if (act && !act_d) begin
            cnt <= stall;
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
         end
         if (ext_data_oe && !(&ext_chip_select_n)) begin
            wr_seen <= ext_data_out;
         end
      end
   end
endmodule

// ===== static_mem_cs_timing_config_bench.sv
`timescale 1ns/1ps
module static_mem_cs_timing_config_bench;
   import static_mem_cfg_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, req_valid = 0, ev;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rv, d;
   logic pready, pslverr, req_ready, rd_valid, ext_data_oe, read_strobe_n, write_strobe_n, ext_wait_n;
   logic byte_select_lo_n, byte_select_hi_n, byte_write_strobe_lo_n, byte_write_strobe_hi_n;
   mem_req_t req = '0;
   logic [15:0] rd_data, rdat, ext_data_out, ext_data_in, wr_seen;
   logic [23:0] ext_addr, b;
   logic [NUM_CS-1:0] ext_chip_select_n;
   logic [5:0] s;
   logic [6:0] p;
   logic [8:0] y;
   int fails = 0, checks = 0, stall = 0, n0, c, r;
   int k[8]; // cycles, we, rd, cs, bw lo, bw hi, bs lo, first strobe
   logic [31:0] rst_v[4] = '{RST_SETUP, RST_PULSE, RST_CYCLE, RST_MODE};
   logic [31:0] msk_v[4] = '{MSK_SETUP, MSK_PULSE, MSK_CYCLE, MSK_MODE};
   always #12.5 pclk = ~pclk;
   static_mem_cs_timing_config uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .req_valid, .req, .req_ready, .rd_data, .rd_valid, .ext_addr, .ext_data_out, .ext_data_oe,
      .ext_data_in, .ext_chip_select_n, .read_strobe_n, .write_strobe_n, .byte_select_lo_n, .byte_select_hi_n,
      .byte_write_strobe_lo_n, .byte_write_strobe_hi_n, .ext_wait_n);
   static_mem_partner pm (.pclk, .presetn, .ext_chip_select_n, .read_strobe_n, .write_strobe_n, .ext_addr,
      .ext_data_out, .ext_data_oe, .stall, .ext_data_in, .ext_wait_n, .wr_seen);
   function automatic int sl(input logic [5:0] f);
      return 128 * f[5] + f[4:0];
   endfunction
   function automatic int pl(input logic [6:0] f);
      return 256 * f[6] + f[5:0];
   endfunction
   function automatic int cl(input logic [8:0] f);
      return 256 * f[8:7] + f[6:0];
   endfunction
   function automatic logic [31:0] md(input logic [1:0] ps, input logic pe, input logic [3:0] fl, input logic byte_access_sel,
      input logic [1:0] wm);
      return {2'h0, ps, 3'h0, pe, 3'h0, 1'b0, fl, 2'h0, 2'h1, 3'h0, byte_access_sel, 2'h0, wm, 2'h0, 2'h3};
   endfunction
   task close_out;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task to_out;
      fails++;
      $display("wrong value at %0t: wait ran out", $time);
      close_out();
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) to_out();
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task cfg(input int cs, input logic [31:0] st, pu, cy, mo);
      apb(1'b1, 12'(cs * 16), st);
      apb(1'b1, 12'(cs * 16 + 4), pu);
      apb(1'b1, 12'(cs * 16 + 8), cy);
      apb(1'b1, 12'(cs * 16 + 12), mo);
   endtask
   task acc(input logic w, input logic [1:0] cs, input logic [23:0] a, input logic [1:0] be, input logic [15:0] wd);
      int n;
      k = '{default: 0};
      @(posedge pclk);
      req_valid <= 1'b1;
      req <= '{w, cs, a, be, wd};
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (req_ready !== 1'b1 && n < 2000);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
         k[1] += (write_strobe_n === 1'b0);
         k[2] += (read_strobe_n === 1'b0);
         k[3] += (ext_chip_select_n[cs] === 1'b0);
         k[4] += (byte_write_strobe_lo_n === 1'b0);
         k[5] += (byte_write_strobe_hi_n === 1'b0);
         k[6] += (byte_select_lo_n === 1'b0);
         if (k[7] == 0 && (write_strobe_n === 1'b0 || read_strobe_n === 1'b0)) k[7] = n;
         if (rd_valid === 1'b1) rdat = rd_data;
      end while (req_ready !== 1'b1 && n < 2000);
      k[0] = n;
      if (n >= 2000) to_out();
   endtask
   initial begin
      void'($urandom(32'h0b030998));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (c = 0; c < 4; c++) begin
         for (r = 0; r < 4; r++) begin
            apb(1'b0, 12'(c * 16 + r * 4), 32'h0);
            chk(rv, rst_v[r]);
         end
      end
      apb(1'b0, 12'h040, 32'h0);
      chk({rv[30:0], ev}, 32'h1);
      repeat (12) begin
         c = $urandom % 4;
         r = $urandom % 4;
         d = $urandom;
         apb(1'b1, 12'(c * 16 + r * 4), d);
         apb(1'b0, 12'(c * 16 + r * 4), 32'h0);
         chk(rv, d & msk_v[r]);
      end
      // staged pulse must not act before the mode write
      cfg(1, RST_SETUP, RST_PULSE, RST_CYCLE, md(0, 0, 0, 0, 0));
      apb(1'b1, 12'h014, 32'h01010105);
      apb(1'b1, 12'h018, 32'h00080008);
      acc(1'b1, 1, 24'h10, 2'b11, 16'h1234);
      chk(k[1], 1);
      apb(1'b1, 12'h01c, md(0, 0, 0, 0, 0));
      acc(1'b1, 1, 24'h12, 2'b11, 16'hbeef);
      chk(k[1], 5);
      chk(wr_seen, 16'hbeef);
      chk(k[6] > 0, 1);
      for (r = 0; r < 3; r++) begin
         s = (r == 0) ? 6'h01 : (r == 1) ? 6'h21 : 6'($urandom % 8);
         p = (r == 0) ? 7'h01 : (r == 1) ? 7'h41 : 7'(1 + $urandom % 8);
         y = (r == 0) ? 9'h003 : (r == 1) ? 9'h1ff : 9'(sl(s) + pl(p) + 1 + $urandom % 8);
         cfg(1, {4{2'h0, s}}, {4{1'b0, p}}, {2{7'h0, y}}, md(0, 0, 0, 0, 0));
         d = $urandom;
         acc(1'b1, 1, 24'h20, 2'b11, d[15:0]);
         chk(k[7], sl(s) + 2);
         chk(k[1], pl(p));
         chk(k[3], pl(p));
         chk(k[0], cl(y) + 2);
         chk(wr_seen, d[15:0]);
      end
      cfg(2, 32'h01010101, 32'h06060101, 32'h000a000a, md(0, 0, 0, 0, 0));
      acc(1'b0, 2, 24'h3456, 2'b11, 16'h0);
      chk(k[2], 6);
      chk(rdat, 16'h3456 ^ 16'h5a5a);
      n0 = k[0];
      apb(1'b1, 12'h02c, md(0, 0, 4'h5, 0, 0));
      acc(1'b0, 2, 24'h0a0c, 2'b11, 16'h0);
      chk(rdat, 16'h0a0c ^ 16'h5a5a);
      chk(k[0] - n0, 5);
      // optimized float lets the next request in at once
      apb(1'b1, 12'h02c, md(0, 0, 4'h5, 0, 0) | 32'h00100000);
      acc(1'b0, 2, 24'h0a10, 2'b11, 16'h0);
      chk(k[0], n0);
      chk(rdat, 16'h0a10 ^ 16'h5a5a);
      cfg(3, 32'h01010101, 32'h08080808, 32'h00280028, md(0, 0, 0, 0, 0));
      for (r = 0; r < 3; r++) begin
         apb(1'b1, 12'h03c, md(0, 0, 0, 0, (r == 0) ? WAIT_OFF : (r == 1) ? WAIT_FROZEN : WAIT_READY));
         stall = (r == 2) ? 14 : 3;
         acc(1'b1, 3, 24'h40, 2'b11, 16'h5555);
         if (r < 2) chk(k[1], (r == 0) ? 8 : 11);
         else chk(k[1] > 8, 1);
      end
      stall = 0;
      apb(1'b1, 12'h03c, md(0, 0, 0, 1, 0));
      acc(1'b1, 3, 24'h44, 2'b01, 16'h00a5);
      chk(k[4], 8);
      chk(k[5], 0);
      chk(k[1], 0);
      cfg(0, 32'h0, 32'h06020101, 32'h000a000a, md(0, 1, 0, 0, 0));
      for (r = 0; r < 4; r++) begin
         apb(1'b1, 12'h00c, md(2'(r), 1, 0, 0, 0));
         b = 24'h200 + 24'(r * 256);
         acc(1'b0, 0, b, 2'b11, 16'h0);
         chk(k[2], 6);
         acc(1'b0, 0, b + 24'((4 << r) - 2), 2'b11, 16'h0);
         chk(k[2], 2);
         acc(1'b0, 0, b + 24'(4 << r), 2'b11, 16'h0);
         chk(k[2], 6);
      end
      apb(1'b1, 12'h00c, md(0, 0, 0, 0, 0));
      acc(1'b0, 0, 24'h900, 2'b11, 16'h0);
      chk(k[2], 2);
      close_out();
   end
endmodule
